// *** sscl_pkg.sv ***
package sscl_pkg;
	// Stop selection encodings (whole seconds)
	localparam logic [13:0] STOP_SEL_TIMED_MAX = 14'd100;
	localparam logic [13:0] STOP_SEL_OFFSET_LO = 14'd1000;
	localparam logic [13:0] STOP_SEL_OFFSET_HI = 14'd1100;
	localparam logic [13:0] STOP_SEL_DECEL_DIR = 14'd8888;
	localparam logic [13:0] STOP_SEL_DECEL = 14'd9999;
	// Terminal function codes
	localparam logic [7:0] FUNC_STOP = 8'h19;
	localparam logic [7:0] FUNC_FLUX_DECAY = 8'h4a;
	localparam logic [7:0] FUNC_NONE = 8'hff;
	// Timing
	localparam int CLK_HZ = 20000000;
	localparam int MS_PER_S = 1000;
	localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
	localparam int DECAY_MS_0 = 250;
	localparam int DECAY_MS_1 = 500;
	localparam int DECAY_MS_2 = 800;
	localparam int DECAY_MS_3 = 900;
	localparam int DECAY_MS_4 = 1100;
	// Motor capacity class thresholds, tenths of kW
	localparam logic [11:0] CAP_CLASS_1 = 12'd37;
	localparam logic [11:0] CAP_CLASS_2 = 12'd150;
	localparam logic [11:0] CAP_CLASS_3 = 12'd370;
	localparam logic [11:0] CAP_CLASS_4 = 12'd750;

	typedef enum logic [3:0] {
		SSCL_STOPPED = 4'b0001,
		SSCL_RUNNING = 4'b0010,
		SSCL_COAST_WAIT = 4'b0100,
		SSCL_DECAY = 4'b1000
	} sscl_state_type;

	typedef struct packed {
		logic run;
		logic reverse;
		logic decel_stop;
		logic coast_stop;
		logic output_on;
	} sscl_drive_cmd_type;
endpackage

// *** sscl_start_stop.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Setting 0-100: per-direction inputs, timed coast
// - Setting 1000-1100: coast after setting minus 1000
// - Setting 9999: per-direction inputs, decelerate on stop
// - 8888/1000-1100: forward runs, reverse gives direction
// - Two-wire: single asserted input picks direction
// - Two-wire: both off or both on decelerates, or coasts for 0-100
// - Stop input asserted enables start self-holding
// - Pulsed start input is latched and runs
// - Stop input deassertion releases hold, decelerates, or coasts for 0-100 and 1000-1100
// - Jog asserted makes stop input ignored
// - Output shutoff keeps latched self-hold state
// - Stop function routable via code 25
// - Start functions mapped on any selection except FUNC_NONE
// - Sensorless vector: flux decay then shutoff, code 74
// - Decay time limited by motor capacity class
// - Other control methods: flux shutoff immediate
// - Restart or online tuning: immediate shutoff
// - Other shutoff during decay aborts immediately
// - Output voltage stays on during flux decay
// - Output shutoff works in every operation mode
module sscl_start_stop
	import sscl_pkg::*;
#(
	parameter int SEC_CYCLES = CLK_HZ,
	parameter int DECAY_SCALE = CYC_PER_MS
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic fwd_start_input,
	input wire logic rev_start_input,
	input wire logic stop_input,
	input wire logic jog_input,
	input wire logic output_shutoff_input,
	input wire logic flux_decay_shutoff_input,
	input wire logic alarm_input,
	input wire logic sensorless_vector,
	input wire logic restart_or_tuning,
	input wire logic [13:0] stop_selection_setting,
	input wire logic [11:0] motor_capacity_setting,
	input wire logic [7:0] fwd_terminal_func_sel,
	input wire logic [7:0] rev_terminal_func_sel,
	input wire logic [7:0] aux_terminal_func_sel,
	input wire logic aux_terminal_input,
	output sscl_drive_cmd_type drive_cmd,
	output sscl_state_type run_state
);
	sscl_state_type state;
	logic fwd_prev;
	logic rev_prev;
	logic hold_active;
	logic hold_reverse;
	logic [31:0] timer;
	logic [31:0] coast_cycles;
	logic [31:0] decay_cycles;
	logic sel_timed;
	logic sel_offset;
	logic dir_mode;
	logic stop_level;
	logic stop_eff;
	logic flux_req;
	logic hard_shutoff;
	logic want_run;
	logic want_rev;
	logic next_want_run;

	// Aux terminal may carry stop (code 25) or flux decay (code 74)
	assign stop_level = stop_input | (aux_terminal_func_sel == FUNC_STOP && aux_terminal_input);
	assign flux_req = flux_decay_shutoff_input
		| (aux_terminal_func_sel == FUNC_FLUX_DECAY && aux_terminal_input);
	// Start functions stay on their own terminals; only FUNC_NONE idles them
	logic fwd_in;
	logic rev_in;
	assign fwd_in = fwd_start_input & (fwd_terminal_func_sel != FUNC_NONE);
	assign rev_in = rev_start_input & (rev_terminal_func_sel != FUNC_NONE);

	assign sel_timed = stop_selection_setting <= STOP_SEL_TIMED_MAX;
	assign sel_offset = stop_selection_setting >= STOP_SEL_OFFSET_LO
		&& stop_selection_setting <= STOP_SEL_OFFSET_HI;
	assign dir_mode = sel_offset || stop_selection_setting == STOP_SEL_DECEL_DIR;
	assign stop_eff = stop_level & ~jog_input;
	assign hard_shutoff = output_shutoff_input | alarm_input;

	always_comb begin
		coast_cycles = 32'(SEC_CYCLES);
		if (sel_offset) begin
			coast_cycles = 32'(SEC_CYCLES) * 32'(stop_selection_setting - STOP_SEL_OFFSET_LO);
		end else if (sel_timed) begin
			coast_cycles = 32'(SEC_CYCLES) * 32'(stop_selection_setting);
		end
	end

	// Longest decay per capacity class
	always_comb begin
		if (motor_capacity_setting < CAP_CLASS_1) begin
			decay_cycles = 32'(DECAY_MS_0 * DECAY_SCALE);
		end else if (motor_capacity_setting < CAP_CLASS_2) begin
			decay_cycles = 32'(DECAY_MS_1 * DECAY_SCALE);
		end else if (motor_capacity_setting < CAP_CLASS_3) begin
			decay_cycles = 32'(DECAY_MS_2 * DECAY_SCALE);
		end else if (motor_capacity_setting < CAP_CLASS_4) begin
			decay_cycles = 32'(DECAY_MS_3 * DECAY_SCALE);
		end else begin
			decay_cycles = 32'(DECAY_MS_4 * DECAY_SCALE);
		end
	end

	// Self-hold latch: pulse a start input, release on stop deassertion
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			fwd_prev <= 1'b0;
			rev_prev <= 1'b0;
			hold_active <= 1'b0;
			hold_reverse <= 1'b0;
		end else begin
			fwd_prev <= fwd_in;
			rev_prev <= rev_in;
			if (!stop_eff) begin
				hold_active <= 1'b0;
			end else if (fwd_prev && !fwd_in) begin
				hold_active <= 1'b1;
				hold_reverse <= 1'b0;
			end else if (rev_prev && !rev_in) begin
				hold_active <= 1'b1;
				hold_reverse <= 1'b1;
			end
			// Shutoff inputs deliberately leave the hold alone
		end
	end

	always_comb begin
		want_rev = 1'b0;
		next_want_run = 1'b0;
		if (stop_eff) begin
			// Three-wire: inputs are triggers only while stop is held
			// A start falling this cycle counts as held, so the run never blips off
			next_want_run = hold_active || fwd_in || rev_in || fwd_prev || rev_prev;
			if (fwd_prev && !fwd_in) begin
				want_rev = 1'b0;
			end else if (rev_prev && !rev_in) begin
				want_rev = 1'b1;
			end else if (hold_active) begin
				want_rev = hold_reverse;
			end else begin
				want_rev = rev_in;
			end
		end else if (dir_mode) begin
			next_want_run = fwd_in;
			want_rev = rev_in;
		end else begin
			next_want_run = fwd_in ^ rev_in;
			want_rev = rev_in;
		end
		want_run = next_want_run;
	end

	// Main sequencer
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= SSCL_STOPPED;
			timer <= 32'h0;
		end else begin
			unique case (state)
				SSCL_STOPPED: begin
					if (want_run && !hard_shutoff && !flux_req) begin
						state <= SSCL_RUNNING;
					end
				end
				SSCL_RUNNING: begin
					if (hard_shutoff) begin
						state <= SSCL_STOPPED;
					end else if (flux_req) begin
						if (sensorless_vector && !restart_or_tuning) begin
							state <= SSCL_DECAY;
							timer <= decay_cycles;
						end else begin
							state <= SSCL_STOPPED;
						end
					end else if (!want_run) begin
						if (sel_timed || sel_offset) begin
							state <= SSCL_COAST_WAIT;
							timer <= coast_cycles;
						end else begin
							state <= SSCL_STOPPED;
						end
					end
				end
				SSCL_COAST_WAIT: begin
					if (hard_shutoff || flux_req) begin
						state <= SSCL_STOPPED;
					end else if (want_run) begin
						state <= SSCL_RUNNING;
					end else if (timer == 32'h0) begin
						state <= SSCL_STOPPED;
					end else begin
						timer <= timer - 32'h1;
					end
				end
				SSCL_DECAY: begin
					if (hard_shutoff || restart_or_tuning || timer == 32'h0) begin
						state <= SSCL_STOPPED;
					end else begin
						timer <= timer - 32'h1;
					end
				end
				default: begin
					state <= SSCL_STOPPED;
				end
			endcase
		end
	end

	// Direction follows demand whenever a run is wanted; frozen otherwise
	logic dir_q;
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dir_q <= 1'b0;
		end else if (want_run) begin
			dir_q <= want_rev;
		end
	end

	// Decel-stop flag: ramp down when run demand ends without coast, shutoff or flux request
	logic decel_q;
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			decel_q <= 1'b0;
		end else begin
			decel_q <= state == SSCL_RUNNING && !want_run && !hard_shutoff && !flux_req
				&& !(sel_timed || sel_offset);
		end
	end

	always_comb begin
		drive_cmd.run = state == SSCL_RUNNING;
		drive_cmd.reverse = dir_q;
		drive_cmd.decel_stop = decel_q;
		drive_cmd.coast_stop = state == SSCL_COAST_WAIT;
		// Decay keeps voltage applied, unlike plain shutoff
		drive_cmd.output_on = state == SSCL_RUNNING || state == SSCL_COAST_WAIT || state == SSCL_DECAY;
	end
	assign run_state = state;

	decay_abort_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		state == SSCL_DECAY && hard_shutoff |=> state == SSCL_STOPPED)
		else $error("decay not aborted on shutoff");
	decay_voltage_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		state == SSCL_DECAY |-> drive_cmd.output_on)
		else $error("output dropped during decay");
	shutoff_cut_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		output_shutoff_input && state == SSCL_RUNNING |=> !drive_cmd.output_on)
		else $error("output shutoff ignored");
	hold_keep_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		hold_active && stop_eff && output_shutoff_input |=> hold_active)
		else $error("hold cleared by shutoff");
	hold_release_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!stop_level && !jog_input |=> !hold_active)
		else $error("hold not released");
	flux_direct_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		state == SSCL_RUNNING && flux_req && (!sensorless_vector || restart_or_tuning)
		|=> state == SSCL_STOPPED)
		else $error("flux shutoff not immediate");
	coast_cancel_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		state == SSCL_COAST_WAIT && want_run && !hard_shutoff && !flux_req |=> state == SSCL_RUNNING)
		else $error("coast not cancelled");
	// Decel flag lands in the same cycle as the state drop
	both_on_stop_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		state == SSCL_RUNNING && !stop_eff && !dir_mode && fwd_in && rev_in && !sel_timed && !sel_offset
		&& !hard_shutoff && !flux_req |=> state == SSCL_STOPPED && drive_cmd.decel_stop)
		else $error("both inputs did not stop");
	start_refused_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		state == SSCL_STOPPED && (hard_shutoff || flux_req) |=> state == SSCL_STOPPED)
		else $error("start taken during shutoff");
	coast_expire_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		state == SSCL_COAST_WAIT && timer == 32'h0 && !want_run |=> state == SSCL_STOPPED)
		else $error("coast timer did not end");
	coast_entry_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		state == SSCL_RUNNING && !want_run && !hard_shutoff && !flux_req && (sel_timed || sel_offset)
		|=> state == SSCL_COAST_WAIT && timer == $past(coast_cycles))
		else $error("coast wait not entered");
	decay_entry_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		state == SSCL_RUNNING && flux_req && !hard_shutoff && sensorless_vector && !restart_or_tuning
		|=> state == SSCL_DECAY && timer == $past(decay_cycles))
		else $error("flux decay not entered");
	hold_latch_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		stop_eff && fwd_prev && !fwd_in |=> hold_active && !hold_reverse)
		else $error("forward pulse not held");
	hold_reverse_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		stop_eff && rev_prev && !rev_in && !(fwd_prev && !fwd_in) |=> hold_active && hold_reverse)
		else $error("reverse pulse not held");
	held_run_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		state == SSCL_RUNNING && stop_eff && fwd_prev && !fwd_in && !hard_shutoff && !flux_req
		|=> state == SSCL_RUNNING)
		else $error("run dropped while latching");
	jog_no_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		jog_input |=> !hold_active)
		else $error("hold kept during jog");
	dir_mode_rev_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!stop_eff && dir_mode && fwd_in && rev_in |=> drive_cmd.reverse)
		else $error("direction input ignored");
	two_wire_rev_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!stop_eff && !dir_mode && rev_in && !fwd_in |=> drive_cmd.reverse)
		else $error("reverse start not reverse");
	decel_once_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		drive_cmd.decel_stop |=> !drive_cmd.decel_stop)
		else $error("decel flag longer than a cycle");
endmodule

// *** sscl_switch_model.sv ***
`timescale 1ns/1ps
module sscl_switch_model (
	input wire logic ref_clk,
	output logic fwd_start_input,
	output logic rev_start_input,
	output logic stop_input
);
	initial begin
		fwd_start_input = 1'h0;
		rev_start_input = 1'h0;
		stop_input = 1'h0;
	end
	// Contacts move on an edge through nonblocking writes, so logic sees them from the next edge
	task automatic set(input logic f, input logic r, input logic s);
		@(posedge ref_clk);
		fwd_start_input <= f;
		rev_start_input <= r;
		stop_input <= s;
	endtask
	// Held start needs a full on-off pulse to change direction
	// Stop contact is left untouched; a pending change to it must not be undone
	task automatic pulse(input logic r);
		@(posedge ref_clk);
		fwd_start_input <= !r;
		rev_start_input <= r;
		repeat (3) @(posedge ref_clk);
		fwd_start_input <= 1'h0;
		rev_start_input <= 1'h0;
	endtask
endmodule

// *** start_stop_command_logic_tb.sv ***
`timescale 1ns/1ps
module start_stop_command_logic_tb;
	import sscl_pkg::*;
	localparam int SEC = 10;
	localparam int DSC = 2;
	typedef struct {logic [13:0] s; logic f; logic r; logic run; logic rv;} sscl_row_type;
	logic ref_clk = 1'h0;
	logic sys_rst = 1'h1;
	logic fwd, rev, stp;
	logic jog = 1'h0, shut = 1'h0, flux = 1'h0, alarm = 1'h0, svc = 1'h0, rot = 1'h0, aux = 1'h0;
	logic [13:0] sel = STOP_SEL_DECEL;
	logic [11:0] cap = 12'h016;
	logic [7:0] fsel = 8'h00, rsel = 8'h00, asel = FUNC_NONE;
	sscl_drive_cmd_type cmd;
	sscl_state_type st;
	int fail_count = 0, comparisons = 0, n, cc, dc, pc;
	sscl_row_type rows [8] = '{
		'{STOP_SEL_DECEL, 1'h1, 1'h0, 1'h1, 1'h0}, '{STOP_SEL_DECEL, 1'h0, 1'h1, 1'h1, 1'h1},
		'{STOP_SEL_DECEL, 1'h1, 1'h1, 1'h0, 1'h0}, '{STOP_SEL_DECEL_DIR, 1'h1, 1'h0, 1'h1, 1'h0},
		'{STOP_SEL_DECEL_DIR, 1'h1, 1'h1, 1'h1, 1'h1}, '{STOP_SEL_DECEL_DIR, 1'h0, 1'h1, 1'h0, 1'h0},
		'{14'h0032, 1'h0, 1'h1, 1'h1, 1'h1}, '{14'h041a, 1'h1, 1'h1, 1'h1, 1'h1}};
	int csel [2] = '{3, 1002};
	logic [11:0] caps [2] = '{12'h016, 12'h2ee};
	int cms [2] = '{DECAY_MS_0, DECAY_MS_4};

	sscl_switch_model sw (.ref_clk(ref_clk), .fwd_start_input(fwd), .rev_start_input(rev), .stop_input(stp));
	sscl_start_stop #(.SEC_CYCLES(SEC), .DECAY_SCALE(DSC)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.fwd_start_input(fwd), .rev_start_input(rev), .stop_input(stp), .jog_input(jog),
		.output_shutoff_input(shut), .flux_decay_shutoff_input(flux), .alarm_input(alarm),
		.sensorless_vector(svc), .restart_or_tuning(rot), .stop_selection_setting(sel),
		.motor_capacity_setting(cap), .fwd_terminal_func_sel(fsel), .rev_terminal_func_sel(rsel),
		.aux_terminal_func_sel(asel), .aux_terminal_input(aux), .drive_cmd(cmd), .run_state(st));

	always #25 ref_clk = ~ref_clk;
	// Counted on the edge so a pulse is never missed between checks
	always @(posedge ref_clk) begin
		if (cmd.coast_stop === 1'h1) cc++;
		if (st === SSCL_DECAY && cmd.output_on === 1'h1) dc++;
		if (cmd.decel_stop === 1'h1) pc++;
	end

	task automatic tick(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask
	task automatic check(input string nm, input logic e, input logic g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %0b seen %0b", nm, e, g);
		end
	endtask
	task automatic check_n(input string nm, input int e, input int g);
		comparisons++;
		if (g != e) begin
			fail_count++;
			$display("MISMATCH %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	task automatic final_report;
		if (fail_count == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic wait_stopped;
		n = 0;
		while (st !== SSCL_STOPPED) begin
			tick(1);
			n++;
			if (n > 5000) begin
				fail_count++;
				final_report();
			end
		end
	endtask

	initial begin
		tick(12);
		sys_rst <= 1'h0;
		check("state after reset", 1'h1, st === SSCL_STOPPED && cmd === '0);
		foreach (rows[i]) begin
			@(posedge ref_clk);
			sel <= rows[i].s;
			sw.set(rows[i].f, rows[i].r, 1'h0);
			tick(3);
			check("run", rows[i].run, cmd.run);
			if (rows[i].run) check("reverse", rows[i].rv, cmd.reverse);
			sw.set(1'h0, 1'h0, 1'h0);
			wait_stopped();
		end
		// Both inputs on while running
		sel <= STOP_SEL_DECEL;
		sw.set(1'h1, 1'h0, 1'h0);
		tick(3);
		pc = 0;
		sw.set(1'h1, 1'h1, 1'h0);
		tick(4);
		check("run both on", 1'h0, cmd.run);
		check_n("decel pulses", 1, pc);
		sw.set(1'h0, 1'h0, 1'h0);
		foreach (csel[i]) begin
			@(posedge ref_clk);
			sel <= 14'(csel[i]);
			sw.set(1'h1, 1'h0, 1'h0);
			tick(3);
			cc = 0;
			sw.set(1'h0, 1'h0, 1'h0);
			wait_stopped();
			check_n("coast cycles", (csel[i] % 1000) * SEC + 1, cc);
		end
		// New start during coast wait cancels the timer
		sw.set(1'h1, 1'h0, 1'h0);
		tick(3);
		sw.set(1'h0, 1'h0, 1'h0);
		tick(5);
		sw.set(1'h1, 1'h0, 1'h0);
		tick(2);
		check("run after cancel", 1'h1, cmd.run);
		check("coast after cancel", 1'h0, cmd.coast_stop);
		sw.set(1'h0, 1'h0, 1'h0);
		wait_stopped();
		// Three-wire hold
		sel <= STOP_SEL_DECEL;
		sw.set(1'h0, 1'h0, 1'h1);
		sw.pulse(1'h0);
		tick(3);
		check("held run", 1'h1, cmd.run);
		sw.pulse(1'h1);
		tick(3);
		check("held reverse", 1'h1, cmd.reverse);
		shut <= 1'h1;
		tick(3);
		check("output cut", 1'h0, cmd.output_on);
		shut <= 1'h0;
		tick(3);
		check("hold kept", 1'h1, cmd.run);
		pc = 0;
		sw.set(1'h0, 1'h0, 1'h0);
		tick(4);
		check("hold released", 1'h0, cmd.run);
		check_n("release decel", 1, pc);
		// Jog voids the stop contact, so a pulse is not held
		jog <= 1'h1;
		sw.set(1'h0, 1'h0, 1'h1);
		sw.pulse(1'h0);
		tick(3);
		check("jog ignores stop", 1'h0, cmd.run);
		jog <= 1'h0;
		sw.set(1'h0, 1'h0, 1'h0);
		// Stop routed to the spare terminal
		asel <= FUNC_STOP;
		aux <= 1'h1;
		sw.pulse(1'h0);
		tick(3);
		check("aux hold", 1'h1, cmd.run);
		aux <= 1'h0;
		tick(3);
		check("aux release", 1'h0, cmd.run);
		asel <= FUNC_NONE;
		fsel <= FUNC_NONE;
		sw.set(1'h1, 1'h0, 1'h0);
		tick(3);
		check("unmapped start", 1'h0, cmd.run);
		fsel <= 8'h00;
		tick(3);
		check("mapped start", 1'h1, cmd.run);
		// Flux decay with the forward input held on throughout
		svc <= 1'h1;
		foreach (caps[i]) begin
			cap <= caps[i];
			tick(3);
			dc = 0;
			flux <= 1'h1;
			tick(2);
			wait_stopped();
			check_n("decay on cycles", cms[i] * DSC + 1, dc);
			flux <= 1'h0;
			tick(3);
		end
		flux <= 1'h1;
		tick(10);
		alarm <= 1'h1;
		tick(2);
		check("decay abort", 1'h0, cmd.output_on);
		{alarm, flux} <= 2'h0;
		tick(3);
		rot <= 1'h1;
		flux <= 1'h1;
		tick(2);
		check("tuning cut", 1'h0, cmd.output_on);
		{rot, flux, svc} <= 3'h0;
		tick(3);
		flux <= 1'h1;
		tick(2);
		check("plain cut", 1'h0, cmd.output_on);
		flux <= 1'h0;
		tick(3);
		sys_rst <= 1'h1;
		tick(2);
		check("reset mid-run", 1'h1, st === SSCL_STOPPED && cmd === '0);
		sys_rst <= 1'h0;
		tick(3);
		check("run after reset", 1'h1, cmd.run);
		final_report();
	end
endmodule
